// ===== verilog/current_dac_serial_control.sv
// Serial control logic of a single-channel current output converter
`timescale 1ns/1ps
// Function
// [R1] Each rising serial clock edge shifts serial_in into the input shift register.
// [R2] Host keeps serial_in stable around every rising serial clock edge.
// [R3] Serial clock runs up to 30 MHz; capture works at any rate below.
// [R4] Strobe rising edge loads the word into the register its address selects.
// [R5] A word addressed to the data register also updates the output code.
// [R6] In readback and daisy-chain modes serial_out changes on falling clock edges.
// [R7] In readback mode serial_out is released after the strobe's rising edge.
// [R8] While clear is high the output is forced to zero scale.
// [R9] Fault output pulls low on open circuit or overtemperature.
// [R10] Word is 24 bits, MSB first: 8 address bits then 16 data bits.
// [R11] Host applies exactly 24 rising clock edges before raising the strobe; t_extra in the testbench applies 32 before one strobe.
// [R12] Shifting ignores the strobe; the last 24 bits before it are latched.
module current_dac_serial_control
  import dac_link_pkg::*;
(
  input  wire logic                              clk,
  input  wire logic                              arst_n,
  input  wire logic                              sclk,
  input  wire logic                              serial_in,
  input  wire logic                              latch,
  input  wire logic                              clear,
  input  wire logic                              open_circuit,
  input  wire logic                              over_temp,
  output logic                                   serial_out,
  output logic                                   serial_out_oe,
  output logic                                   fault_out,
  output logic                                   fault_oe,
  output logic [dac_link_pkg::DATA_BITS-1:0]     out_code,
  output logic [dac_link_pkg::RANGE_BITS-1:0]    out_range
);
  import dac_link_pkg::*;

  logic [WORD_BITS-1:0]  sreg_q;
  logic                  chain_q;
  logic [IDX_BITS-1:0]   fall_cnt_q;
  logic [WORD_BITS-1:0]  w1_q;
  logic [WORD_BITS-1:0]  w2_q;
  logic [WORD_BITS-1:0]  w3_q;
  logic                  pend_q;
  logic                  cap_fire;
  logic [ADDR_BITS-1:0]  cap_addr;
  logic [DATA_BITS-1:0]  cap_data;
  logic [DATA_BITS-1:0]  code_q;
  logic [DATA_BITS-1:0]  ctrl_q;
  logic [DATA_BITS-1:0]  out_code_q;
  logic [RANGE_BITS-1:0] out_range_q;
  logic                  rb_active_q;
  logic [WORD_BITS-1:0]  rb_word_q;
  logic                  fault_q;
  logic [3:0]            pin_level;
  logic [3:0]            pin_rise;
  logic                  latch_rise;
  logic                  clear_lvl;
  logic                  open_lvl;
  logic                  temp_lvl;
  logic                  daisy_en;
  logic [DATA_BITS-1:0]  status_word;

  // Readback word for a given selector
  function automatic logic [WORD_BITS-1:0] rb_select(
    input logic [RB_SEL_BITS-1:0] sel,
    input logic [DATA_BITS-1:0]   code,
    input logic [DATA_BITS-1:0]   ctrl,
    input logic [DATA_BITS-1:0]   stat
  );
    logic [WORD_BITS-1:0] w;
    w = {ADDR_STATUS, stat};
    if (sel == RB_SEL_DATA) begin
      w = {ADDR_DATA, code};
    end else if (sel == RB_SEL_CTRL) begin
      w = {ADDR_CTRL, ctrl};
    end
    return w;
  endfunction

  // ********************************
  // Link clock domain
  // ********************************
  // Shift in MSB first, strobe level never gates it
  always_ff @(posedge sclk or negedge arst_n) begin
    if (!arst_n) begin
      sreg_q <= '0;
    end else begin
      sreg_q <= {sreg_q[WORD_BITS-2:0], serial_in}; // [R1] [R3] [R10] [R12]
    end
  end

  a_shift_in: assert property (@(posedge sclk) disable iff (!arst_n) // [R1]
    1'b1 |=> sreg_q[0] == $past(serial_in)) else $error("serial_in not shifted in");
  a_shift_keep: assert property (@(posedge sclk) disable iff (!arst_n) // [R12]
    1'b1 |=> sreg_q[WORD_BITS-1:1] == $past(sreg_q[WORD_BITS-2:0]))
    else $error("shift register lost bits");

  // Daisy-chain output bit, launched on the falling edge
  always_ff @(negedge sclk or negedge arst_n) begin
    if (!arst_n) begin
      chain_q <= 1'b0;
    end else begin
      chain_q <= sreg_q[WORD_BITS-1]; // [R6]
    end
  end

  // Falling edge position within the frame, frames are whole words
  always_ff @(negedge sclk or negedge arst_n) begin
    if (!arst_n) begin
      fall_cnt_q <= '0;
    end else if (fall_cnt_q == LAST_IDX) begin
      fall_cnt_q <= '0; // [R11]
    end else begin
      fall_cnt_q <= fall_cnt_q + 5'h01; // [R6]
    end
  end

  a_chain_out: assert property (@(negedge sclk) disable iff (!arst_n) // [R6]
    1'b1 |=> chain_q == $past(sreg_q[WORD_BITS-1])) else $error("chain bit wrong");

  // ********************************
  // Pin synchronisers
  // ********************************
  in_sync3 #(
    .WIDTH (4)
  ) u_pin_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .din    ({over_temp, open_circuit, clear, latch}),
    .level  (pin_level),
    .rise   (pin_rise)
  );

  assign latch_rise = pin_rise[0];
  assign clear_lvl  = pin_level[1];
  assign open_lvl   = pin_level[2];
  assign temp_lvl   = pin_level[3];

  // ********************************
  // Word capture
  // ********************************
  // Shift register is quiet at the strobe; two equal samples mark it settled
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      w1_q <= '0;
      w2_q <= '0;
      w3_q <= '0;
    end else begin
      w1_q <= sreg_q;
      w2_q <= w1_q;
      w3_q <= w2_q;
    end
  end

  assign cap_fire = pend_q && (w2_q == w3_q);
  assign cap_addr = w3_q[ADDR_MSB:ADDR_LSB];
  assign cap_data = w3_q[DATA_BITS-1:0];

  // Pending load, a new strobe edge wins over completion
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_q <= 1'b0;
    end else if (latch_rise) begin
      pend_q <= 1'b1; // [R4]
    end else if (cap_fire) begin
      pend_q <= 1'b0;
    end
  end

  a_capture_time: assert property (@(posedge clk) disable iff (!arst_n) // [R4]
    latch_rise |=> ##[0:8] cap_fire) else $error("strobe not captured in time");

  // ********************************
  // Internal registers
  // ********************************
  // Data and control registers by address
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      code_q <= CODE_RESET;
      ctrl_q <= CTRL_RESET;
    end else if (cap_fire) begin
      if (cap_addr == ADDR_DATA) begin
        code_q <= cap_data; // [R4] [R10]
      end
      if (cap_addr == ADDR_CTRL) begin
        ctrl_q <= cap_data; // [R4]
      end
    end
  end

  a_ctrl_load: assert property (@(posedge clk) disable iff (!arst_n) // [R4]
    cap_fire && cap_addr == ADDR_CTRL |=> ctrl_q == $past(cap_data))
    else $error("control register not loaded");

  // Output code follows the data word, clear forces zero scale
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      out_code_q  <= ZERO_SCALE;
      out_range_q <= RANGE_4_20;
    end else begin
      out_range_q <= ctrl_q[RANGE_LSB +: RANGE_BITS];
      if (clear_lvl) begin
        out_code_q <= ZERO_SCALE; // [R8]
      end else if (cap_fire && cap_addr == ADDR_DATA) begin
        out_code_q <= cap_data; // [R5]
      end else begin
        out_code_q <= code_q;
      end
    end
  end

  a_code_update: assert property (@(posedge clk) disable iff (!arst_n) // [R5]
    cap_fire && cap_addr == ADDR_DATA && !clear_lvl |=> out_code_q == $past(cap_data))
    else $error("output code not updated");
  a_clear_zero: assert property (@(posedge clk) disable iff (!arst_n) // [R8]
    clear_lvl [*2] |=> out_code_q == ZERO_SCALE) else $error("clear did not zero output");

  // ********************************
  // Readback and serial output
  // ********************************
  // Status bits at their field positions, the rest read as zero
  always_comb begin
    status_word                 = '0;
    status_word[STAT_OPEN_BIT]  = open_lvl;
    status_word[STAT_TEMP_BIT]  = temp_lvl;
    status_word[STAT_FAULT_BIT] = fault_q;
  end

  assign daisy_en    = ctrl_q[CTRL_DAISY_BIT];

  // Readback window opens on a select word and closes at the next strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rb_active_q <= 1'b0;
      rb_word_q   <= '0;
    end else if (latch_rise) begin
      rb_active_q <= 1'b0; // [R7]
    end else if (cap_fire && cap_addr == ADDR_READBACK) begin
      rb_active_q <= 1'b1;
      rb_word_q   <= rb_select(cap_data[RB_SEL_BITS-1:0], code_q, ctrl_q, status_word);
    end
  end

  a_rb_release: assert property (@(posedge clk) disable iff (!arst_n) // [R7]
    latch_rise && !daisy_en |=> !serial_out_oe) else $error("readback not released");

  // Readback bit indexed by falling edge count; words held static across frames
  assign serial_out    = daisy_en ? chain_q : rb_word_q[LAST_IDX - fall_cnt_q]; // [R6]
  assign serial_out_oe = daisy_en | rb_active_q;

  // ********************************
  // Fault alert
  // ********************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= open_lvl | temp_lvl; // [R9]
    end
  end

  // Open drain: drive low only
  assign fault_out = 1'b0;
  assign fault_oe  = fault_q;

  a_fault_low: assert property (@(posedge clk) disable iff (!arst_n) // [R9]
    (open_lvl || temp_lvl) |=> fault_oe && !fault_out) else $error("fault not pulled low");
  a_fault_free: assert property (@(posedge clk) disable iff (!arst_n) // [R9]
    !(open_lvl || temp_lvl) |=> !fault_oe) else $error("fault held without cause");

  assign out_code  = out_code_q;
  assign out_range = out_range_q;
endmodule // current_dac_serial_control

// ===== common/dac_link_pkg.sv
// Shared constants for the current converter serial control block
package dac_link_pkg;
  // ********************************
  // Serial word layout
  // ********************************
  localparam int WORD_BITS = 24;
  localparam int ADDR_BITS = 8;
  localparam int DATA_BITS = 16;
  localparam int ADDR_MSB  = 23;
  localparam int ADDR_LSB  = 16;
  localparam int IDX_BITS  = 5;
  localparam logic [IDX_BITS-1:0] LAST_IDX = 5'h17;

  // ********************************
  // Register addresses
  // ********************************
  localparam logic [ADDR_BITS-1:0] ADDR_NOP      = 8'h00;
  localparam logic [ADDR_BITS-1:0] ADDR_DATA     = 8'h01;
  localparam logic [ADDR_BITS-1:0] ADDR_READBACK = 8'h02;
  localparam logic [ADDR_BITS-1:0] ADDR_CTRL     = 8'h55;
  localparam logic [ADDR_BITS-1:0] ADDR_STATUS   = 8'h03;

  // ********************************
  // Fields and reset values
  // ********************************
  localparam int RANGE_LSB      = 0;
  localparam int RANGE_BITS     = 3;
  localparam int CTRL_DAISY_BIT = 3;
  localparam int RB_SEL_BITS    = 2;
  localparam int STAT_OPEN_BIT  = 0;
  localparam int STAT_TEMP_BIT  = 1;
  localparam int STAT_FAULT_BIT = 2;
  localparam logic [RB_SEL_BITS-1:0] RB_SEL_STATUS = 2'h0;
  localparam logic [RB_SEL_BITS-1:0] RB_SEL_DATA   = 2'h1;
  localparam logic [RB_SEL_BITS-1:0] RB_SEL_CTRL   = 2'h2;
  localparam logic [RANGE_BITS-1:0]  RANGE_4_20    = 3'h0;
  localparam logic [RANGE_BITS-1:0]  RANGE_0_20    = 3'h1;
  localparam logic [RANGE_BITS-1:0]  RANGE_0_24    = 3'h2;
  localparam logic [DATA_BITS-1:0]   CODE_RESET    = 16'h0000;
  localparam logic [DATA_BITS-1:0]   CTRL_RESET    = 16'h0000;
  localparam logic [DATA_BITS-1:0]   ZERO_SCALE    = 16'h0000;

  // ********************************
  // Timing
  // ********************************
  localparam int SCLK_MAX_MHZ  = 30;
  localparam int CLK_MHZ       = 100;
  localparam int SYNC_STAGES   = 3;
  localparam int CAPTURE_MAX_CYC = 8;
endpackage

// ===== verilog/in_sync3.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module in_sync3 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] lvl_q;
  logic [WIDTH-1:0] lvl_d;

  // ********************************
  // Synchroniser chain
  // ********************************
  // Stage one feeds stage two only
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Level moves only when stages two and three agree
  assign lvl_d = (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lvl_q <= '0;
    end else begin
      lvl_q <= lvl_d;
    end
  end

  // Outputs
  assign level = lvl_q;
  assign rise  = lvl_d & ~lvl_q;
endmodule // in_sync3

// ===== sim/host_link_model.sv
// Host serial port model driving the converter's three-wire link
`timescale 1ns/1ps
module host_link_model (
  output logic      sclk,
  output logic      serial_in,
  output logic      latch,
  input  wire logic serial_out
);
  // ********************************
  // Frame driver
  // ********************************
  // Link clock stands still and low between frames
  initial begin
    sclk      = 1'b0;
    serial_in = 1'b0;
    latch     = 1'b0;
  end

  // Shifts n bits MSB first at 64 ns period, reads serial_out on rising edges
  task automatic frame(input logic [31:0] w, input int n, input bit strobe,
                       output logic [23:0] rb);
    rb = 24'h000000;
    for (int i = n - 1; i >= 0; i--) begin
      serial_in = w[i];
      #16;
      sclk = 1'b1;
      rb = {rb[22:0], serial_out};
      #32;
      serial_in = ~w[i];
      sclk = 1'b0;
      #16;
    end
    // Strobe only after the last rising edge of the frame
    if (strobe) begin
      #40;
      latch = 1'b1;
      #100;
      latch = 1'b0;
      #200;
    end
  endtask
endmodule // host_link_model

// ===== sim/tb.sv
// Self-checking testbench for the converter serial control block
`timescale 1ns/1ps
module tb;
  import dac_link_pkg::*;
  logic                  clk;
  logic                  arst_n;
  logic                  clear;
  logic                  open_circuit;
  logic                  over_temp;
  wire logic             sclk;
  wire logic             serial_in;
  wire logic             latch;
  logic                  serial_out;
  logic                  sdo_line;
  logic                  serial_out_oe;
  logic                  fault_out;
  logic                  fault_oe;
  logic [DATA_BITS-1:0]  out_code;
  logic [RANGE_BITS-1:0] out_range;
  logic [23:0]           rb;
  int                    err_count;
  int                    n_compared;

  current_dac_serial_control dut_u (.clk(clk), .arst_n(arst_n), .sclk(sclk),
    .serial_in(serial_in), .latch(latch), .clear(clear), .open_circuit(open_circuit),
    .over_temp(over_temp), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .fault_out(fault_out), .fault_oe(fault_oe), .out_code(out_code),
    .out_range(out_range));

  // Released output shows the inverse so a read outside the window is caught
  assign sdo_line = serial_out_oe ? serial_out : ~serial_out;

  host_link_model host_u (.sclk(sclk), .serial_in(serial_in), .latch(latch),
    .serial_out(sdo_line));

  // ********************************
  // Helpers
  // ********************************
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    if (err_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    host_u.frame({8'h00, a, d}, 24, 1'b1, rb);
  endtask

  // ********************************
  // Scenarios
  // ********************************
  task automatic t_reset();
    chk(out_code, CODE_RESET);
    chk(out_range, RANGE_4_20);
    chk(serial_out_oe, 1'b0);
    chk(fault_oe, 1'b0);
    chk(fault_out, 1'b0);
  endtask

  task automatic t_write();
    wr(ADDR_DATA, 16'hA5C3);
    chk(out_code, 16'hA5C3);
  endtask

  task automatic t_ranges();
    logic [RANGE_BITS-1:0] r[3] = '{RANGE_4_20, RANGE_0_20, RANGE_0_24};
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_CTRL, {13'h0000, r[i]});
      chk(out_range, r[i]);
      chk(out_code, 16'hA5C3);
    end
  endtask

  task automatic t_clear();
    @(posedge clk) clear <= 1'b1;
    repeat (10) @(posedge clk);
    chk(out_code, ZERO_SCALE);
    @(posedge clk) clear <= 1'b0;
    repeat (10) @(posedge clk);
    chk(out_code, 16'hA5C3);
  endtask

  task automatic t_fault();
    logic [DATA_BITS-1:0] st;
    for (int k = 0; k < 4; k++) begin
      @(posedge clk) {open_circuit, over_temp} <= 2'(k);
      repeat (10) @(posedge clk);
      chk(fault_oe, k != 0);
      chk(fault_out, 1'b0);
    end
    // Both causes still present: read the status word back
    st                 = '0;
    st[STAT_OPEN_BIT]  = 1'b1;
    st[STAT_TEMP_BIT]  = 1'b1;
    st[STAT_FAULT_BIT] = 1'b1;
    wr(ADDR_READBACK, {14'h0000, RB_SEL_STATUS});
    wr(ADDR_NOP, 16'h0000);
    chk(rb, {ADDR_STATUS, st});
    @(posedge clk) {open_circuit, over_temp} <= 2'b00;
    repeat (10) @(posedge clk);
    chk(fault_oe, 1'b0);
  endtask

  task automatic t_readback();
    wr(ADDR_READBACK, {14'h0000, RB_SEL_DATA});
    chk(serial_out_oe, 1'b1);
    wr(ADDR_NOP, 16'h0000);
    chk(rb, {ADDR_DATA, 16'hA5C3});
    chk(serial_out_oe, 1'b0);
    wr(ADDR_READBACK, {14'h0000, RB_SEL_CTRL});
    wr(ADDR_NOP, 16'h0000);
    chk(rb, {ADDR_CTRL, 13'h0000, RANGE_0_24});
    chk(serial_out_oe, 1'b0);
  endtask

  task automatic t_daisy();
    wr(ADDR_CTRL, 16'h0008);
    chk(serial_out_oe, 1'b1);
    wr(ADDR_CTRL, 16'h0000);
    chk(rb, {ADDR_CTRL, 16'h0008});
    chk(serial_out_oe, 1'b0);
  endtask

  task automatic t_extra();
    host_u.frame(32'h0000_00FF, 8, 1'b0, rb);
    wr(ADDR_DATA, 16'h1234);
    chk(out_code, 16'h1234);
  endtask

  // ********************************
  // Clock, reset and sequence
  // ********************************
  // Free-running system clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Cuts a hang short well beyond the expected run
  initial begin
    #200000;
    err_count++;
    end_sim();
  end

  // Main sequence
  initial begin
    err_count    = 0;
    n_compared   = 0;
    arst_n       <= 1'b0;
    clear        <= 1'b0;
    open_circuit <= 1'b0;
    over_temp    <= 1'b0;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_write();
    t_ranges();
    t_clear();
    t_fault();
    t_readback();
    t_daisy();
    t_extra();
    end_sim();
  end
endmodule // tb
